// [spc_checker.v]
// Purpose: Protection checker for protected-mode memory references.
// Assumes: Single 200 MHz clock, synchronous active-low reset, AXI4-Lite config.
// Notes: Checks are purely combinational alongside translation; result is
//        registered once, the same stage in which translation completes.
//
// Function
// - Check all before cycle; fault blocks access
// - Checks run alongside translation, no added cycles
// - Five check categories implemented
// - Protected flag enables segment checks
// - No bit disables segment checks
// - Level zero passes privilege, keeps limit/type
// - Paging flag auto-enables page checks when protected
// - Descriptor bit 12 is class flag
// - Descriptor bits 8-11 are segment type
// - Limit from dw0[15:0] and dw1[19:16]
// - Descriptor level from dw1 bits 13-14
// - Selector low two bits are requested level
// - Code segment low bits are current level
// - Entry bit 2 is user/supervisor
// - Entry bit 1 is read/write
// - Four segment levels, two page classes
// - Segments need not align with pages
// - Block outward-to-inward access except gates
// - Levels 0-3, violation raises general fault
`timescale 1ns/10ps
`include "spc_defs.vh"

module spc_checker #(
   parameter ADDR_W = 4
) (
   aclk,
   aresetn,
   // AXI4-Lite slave
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready,
   // Reference from the pipeline / translation unit
   ref_valid,
   ref_offset,
   ref_size,
   ref_write,
   ref_exec,
   ref_priv_instr,
   ref_gate_entry,
   ref_sel,
   ref_desc_dw0,
   ref_desc_dw1,
   ref_cs_sel,
   ref_pde,
   ref_pte,
   // To memory
   mem_req,
   // To exception unit
   general_protection_fault,
   page_fault,
   fault_src,
   fault_cat
);
   input wire aclk;
   input wire aresetn;
   input wire [ADDR_W-1:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output wire s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output wire s_axi_wready;
   output wire [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [ADDR_W-1:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;
   input wire ref_valid;
   input wire [31:0] ref_offset;
   input wire [1:0] ref_size;           // 0 byte, 1 word, 2 dword, 3 qword
   input wire ref_write;
   input wire ref_exec;
   input wire ref_priv_instr;           // Instruction needs level 0
   input wire ref_gate_entry;           // Control transfer via defined gate
   input wire [15:0] ref_sel;
   input wire [31:0] ref_desc_dw0;
   input wire [31:0] ref_desc_dw1;
   input wire [15:0] ref_cs_sel;
   input wire [31:0] ref_pde;
   input wire [31:0] ref_pte;
   output reg mem_req;
   output reg general_protection_fault;
   output reg page_fault;
   output reg fault_src;
   output reg [4:0] fault_cat;          // limit,type,domain,entry,instr

   // ==========================================
   // Control and status registers
   // ==========================================
   reg prot_mode_flag_q;                // Protected mode on
   reg paging_on_flag_q;                // Paging on
   reg wguard_q;                        // Supervisor write guard
   reg last_src_q;                      // Source of last fault
   reg [4:0] last_cat_q;                // Categories of last fault
   reg seg_seen_q;                      // Sticky segment fault seen
   reg page_seen_q;                     // Sticky page fault seen
   reg [15:0] fault_cnt_q;              // Fault counter, saturating

   // ==========================================
   // AXI4-Lite write path
   // ==========================================
   reg [ADDR_W-1:0] awaddr_q;
   reg aw_have_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_have_q;
   wire wr_fire;
   wire stat_clr;

   // Accept each channel once per write; hold until response is taken
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign s_axi_bresp = 2'h0;
   assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
   assign stat_clr = wr_fire && (awaddr_q == `SPC_OFF_STAT) && wstrb_q[0] && wdata_q[0];

   // Capture address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_q <= {ADDR_W{1'b0}};
         aw_have_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         w_have_q <= 1'b0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            aw_have_q <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            w_have_q <= 1'b1;
         end
         if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control register; unmapped writes are accepted and dropped
   always @(posedge aclk) begin
      if (!aresetn) begin
         prot_mode_flag_q <= 1'b0;
         paging_on_flag_q <= 1'b0;
         wguard_q <= 1'b0;
      end else if (wr_fire && (awaddr_q == `SPC_OFF_CTRL) && wstrb_q[0]) begin
         prot_mode_flag_q <= wdata_q[`SPC_CTRL_PROT];
         paging_on_flag_q <= wdata_q[`SPC_CTRL_PAGING];
         wguard_q <= wdata_q[`SPC_CTRL_WGUARD];
      end
   end

   // ==========================================
   // AXI4-Lite read path
   // ==========================================
   assign s_axi_arready = !s_axi_rvalid;

   // Read data registered; unmapped addresses read zero with OKAY
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         case (s_axi_araddr)
            `SPC_OFF_CTRL: s_axi_rdata <= {29'h0, wguard_q, paging_on_flag_q, prot_mode_flag_q};
            `SPC_OFF_STAT: s_axi_rdata <= {16'h0, 8'h0, last_cat_q, last_src_q, page_seen_q, seg_seen_q};
            `SPC_OFF_CNT: s_axi_rdata <= {16'h0, fault_cnt_q};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ==========================================
   // Field decode
   // ==========================================
   wire desc_class;                     // 1 = code/data, 0 = system
   wire [3:0] seg_type;
   wire [19:0] seg_limit;
   wire [1:0] descriptor_priv_level;
   wire [1:0] selector_requested_level;
   wire [1:0] current_priv_level;
   wire gran;
   wire [31:0] eff_limit;
   wire is_code;
   wire type_rw;                        // Readable code / writable data
   wire expand_down;
   wire big;

   assign desc_class = ref_desc_dw1[`SPC_DW1_CLASS];
   assign seg_type = ref_desc_dw1[`SPC_DW1_TYPE];
   assign seg_limit = {ref_desc_dw1[`SPC_DW1_LIM_HI], ref_desc_dw0[`SPC_DW0_LIM_LO]};
   assign descriptor_priv_level = ref_desc_dw1[`SPC_DW1_LVL];
   assign selector_requested_level = ref_sel[`SPC_SEL_LVL];
   assign current_priv_level = ref_cs_sel[`SPC_SEL_LVL];
   assign gran = ref_desc_dw1[23];
   assign big = ref_desc_dw1[22];
   assign is_code = seg_type[3];
   assign type_rw = seg_type[1];
   assign expand_down = !seg_type[3] && seg_type[2];
   // Granular limits scale by 4 KByte with low offset bits unchecked
   assign eff_limit = gran ? {seg_limit, 12'hfff} : {12'h000, seg_limit};

   // ==========================================
   // Segment checks (combinational, alongside translation)
   // ==========================================
   reg [32:0] last_byte;
   reg lim_bad;
   reg type_bad;
   reg dom_bad;
   reg entry_bad;
   reg instr_bad;
   reg [1:0] eff_level;

   // All five categories evaluated in the same cycle
   always @* begin
      last_byte = {1'b0, ref_offset} + {29'h0, ((4'h1 << ref_size) - 4'h1)};
      // Limit check; segments need not align with pages
      if (expand_down) begin
         lim_bad = (ref_offset <= eff_limit) || (last_byte > (big ? 33'h0ffff_ffff : 33'h0_0000_ffff));
      end else begin
         lim_bad = last_byte > {1'b0, eff_limit};
      end
      // Type check
      if (!desc_class) begin
         type_bad = 1'b1;
      end else if (ref_exec) begin
         type_bad = !is_code;
      end else if (ref_write) begin
         type_bad = is_code || !type_rw;
      end else begin
         type_bad = is_code && !type_rw;
      end
      // Levels 0..3, larger is less privileged
      eff_level = (current_priv_level > selector_requested_level) ? current_priv_level : selector_requested_level;
      // All-zero levels compare equal and always pass
      dom_bad = !ref_exec && (eff_level > descriptor_priv_level);
      // Inward code entry only through defined gates
      entry_bad = ref_exec && !ref_gate_entry && (current_priv_level != descriptor_priv_level);
      instr_bad = ref_priv_instr && (current_priv_level != 2'h0);
   end

   // Segment checks cannot be switched off while protected
   wire seg_fault;
   assign seg_fault = prot_mode_flag_q && (lim_bad || type_bad || dom_bad || entry_bad || instr_bad);

   // ==========================================
   // Page checks: two classes, user and supervisor
   // ==========================================
   wire user_mode;
   wire page_us;
   wire page_wr;
   wire page_viol;

   assign user_mode = (current_priv_level == 2'h3);
   assign page_us = ref_pde[`SPC_PTE_US] && ref_pte[`SPC_PTE_US];
   assign page_wr = ref_pde[`SPC_PTE_WR] && ref_pte[`SPC_PTE_WR];
   // Enabled with paging in protected mode, no separate off bit; all-user-writable neutralises it
   assign page_viol = prot_mode_flag_q && paging_on_flag_q &&
                      ((user_mode && (!page_us || (ref_write && !page_wr))) ||
                       (!user_mode && ref_write && wguard_q && !page_wr));

   // ==========================================
   // Result stage
   // ==========================================
   // Memory request only issued when every check passed
   always @(posedge aclk) begin
      if (!aresetn) begin
         mem_req <= 1'b0;
         general_protection_fault <= 1'b0;
         page_fault <= 1'b0;
         fault_src <= `SPC_SRC_SEG;
         fault_cat <= 5'h00;
      end else begin
         mem_req <= ref_valid && !seg_fault && !page_viol;
         general_protection_fault <= ref_valid && seg_fault;
         page_fault <= ref_valid && !seg_fault && page_viol;
         if (ref_valid && (seg_fault || page_viol)) begin
            // Segment faults take priority over page faults
            fault_src <= seg_fault ? `SPC_SRC_SEG : `SPC_SRC_PAGE;
            fault_cat <= seg_fault ? {instr_bad, entry_bad, dom_bad, type_bad, lim_bad} : 5'h00;
         end
      end
   end

   // Sticky status; a new fault wins over a same-cycle clear
   always @(posedge aclk) begin
      if (!aresetn) begin
         seg_seen_q <= 1'b0;
         page_seen_q <= 1'b0;
         last_src_q <= 1'b0;
         last_cat_q <= 5'h00;
         fault_cnt_q <= 16'h0000;
      end else begin
         if (stat_clr) begin
            seg_seen_q <= 1'b0;
            page_seen_q <= 1'b0;
         end
         if (ref_valid && seg_fault) begin
            seg_seen_q <= 1'b1;
            last_src_q <= `SPC_SRC_SEG;
            last_cat_q <= {instr_bad, entry_bad, dom_bad, type_bad, lim_bad};
         end else if (ref_valid && page_viol) begin
            page_seen_q <= 1'b1;
            last_src_q <= `SPC_SRC_PAGE;
            last_cat_q <= 5'h00;
         end
         if (ref_valid && (seg_fault || page_viol) && (fault_cnt_q != 16'hffff)) begin
            fault_cnt_q <= fault_cnt_q + 16'h0001;
         end
      end
   end

endmodule

// [spc_checker_props.sv]
// Purpose: Concurrent checks on the protection checker ports
// Assumes: One clock domain, synchronous active-low reset
// Notes: Inputs of the last reference are kept in helper flops
`timescale 1ns/10ps
`include "spc_defs.vh"
module spc_checker_props (
   input logic aclk,
   input logic aresetn,
   input logic ref_valid,
   input logic ref_priv_instr,
   input logic [15:0] ref_sel,
   input logic [15:0] ref_cs_sel,
   input logic [31:0] ref_desc_dw1,
   input logic [31:0] ref_pde,
   input logic [31:0] ref_pte,
   input logic mem_req,
   input logic general_protection_fault,
   input logic page_fault,
   input logic fault_src,
   input logic [4:0] fault_cat
);
   // ==========================================
   // Helper logic
   // ==========================================
   logic [1:0] cur_lvl_q; // Current level of the last reference
   logic instr_q; // Last reference needed level zero
   logic cls_q; // Last descriptor was an application one
   logic open_q; // Both entries user and writable
   // Keep the cause, the answer comes one cycle later
   always_ff @(posedge aclk) begin
      cur_lvl_q <= ref_cs_sel[1:0];
      instr_q <= ref_priv_instr;
      cls_q <= ref_desc_dw1[12];
      open_q <= ref_pde[2] & ref_pde[1] & ref_pte[2] & ref_pte[1];
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // A reference and the cycle of its answer
   sequence s_ref;
      ref_valid ##1 1'b1;
   endsequence
   // A reference with every level at zero
   sequence s_lvl0;
      ref_valid && ref_sel[1:0] == 2'b00 && ref_cs_sel[1:0] == 2'b00 && ref_desc_dw1[14:13] == 2'b00;
   endsequence
   // ==========================================
   // Assertions
   // ==========================================
   AST_ONE_ANSWER: assert property (s_ref |-> $onehot({mem_req, general_protection_fault, page_fault}))
      else $error("Reference without exactly one answer");
   AST_PASS_CAUSE: assert property (mem_req |-> $past(ref_valid))
      else $error("Memory request without a reference");
   AST_SEG_SRC: assert property (general_protection_fault |-> fault_src == `SPC_SRC_SEG && fault_cat != 5'h00)
      else $error("Segment fault with wrong source");
   AST_PAGE_SRC: assert property (page_fault |-> fault_src == `SPC_SRC_PAGE && fault_cat == 5'h00)
      else $error("Page fault with wrong source");
   AST_LEVEL_ZERO: assert property (s_lvl0 |=> !(general_protection_fault && |fault_cat[4:2]))
      else $error("Privilege fault with all levels zero");
   AST_INSTR_LEVEL: assert property (general_protection_fault && fault_cat[4] |-> instr_q && cur_lvl_q != 2'b00)
      else $error("Instruction fault at level zero");
   AST_CLASS_TYPE: assert property (general_protection_fault && !fault_cat[1] |-> cls_q)
      else $error("System descriptor passed the type check");
   AST_PAGE_OPEN: assert property (page_fault |-> !open_q)
      else $error("Page fault on a user writable page");
endmodule
bind spc_checker spc_checker_props u_props (.*);

// [spc_defs.vh]
// Purpose: Constants for the segment and page protection checker.
// Assumes: Included by bare name; definitions only.
// Notes: Register offsets are byte addresses on the AXI4-Lite slave.
`ifndef SPC_DEFS_VH
`define SPC_DEFS_VH

// ==========================================
// Register offsets
// ==========================================
`define SPC_OFF_CTRL 4'h0
`define SPC_OFF_STAT 4'h4
`define SPC_OFF_CNT 4'h8

// ==========================================
// Control register fields
// ==========================================
`define SPC_CTRL_PROT 0
`define SPC_CTRL_PAGING 1
`define SPC_CTRL_WGUARD 2
`define SPC_CTRL_RST 32'h0000_0000

// ==========================================
// Descriptor and selector fields
// ==========================================
`define SPC_DW1_LIM_HI 19:16
`define SPC_DW1_TYPE 11:8
`define SPC_DW1_CLASS 12
`define SPC_DW1_LVL 14:13
`define SPC_DW0_LIM_LO 15:0
`define SPC_SEL_LVL 1:0
`define SPC_PTE_WR 1
`define SPC_PTE_US 2

// ==========================================
// Fault source codes
// ==========================================
`define SPC_SRC_SEG 1'b0
`define SPC_SRC_PAGE 1'b1

// ==========================================
// Timing
// ==========================================
`define SPC_CHECK_CYCLES 1

`endif

// [spc_xcpt_model.sv]
// Purpose: Exception unit and memory side seen by the checker
// Assumes: Answers are one-cycle pulses
// Notes: Only tallies outcomes, it never stalls the checker
`timescale 1ns/10ps
module spc_xcpt_model (
   input logic aclk,
   input logic aresetn,
   input logic mem_req,
   input logic general_protection_fault,
   input logic page_fault
);
   int npass; // Memory cycles started
   int ngp; // Segment faults taken
   // Each pulse is one event, so count every high cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         npass <= 0;
         ngp <= 0;
      end else begin
         npass <= npass + int'(mem_req);
         ngp <= ngp + int'(general_protection_fault);
      end
   end
endmodule

// [testbench.sv]
// Purpose: Directed test of the protection checker
// Assumes: 200 MHz clock, reset held 12 cycles
// Notes: Descriptor low word fixed except in the 0x1234 limit test, limit low part 0xff
`timescale 1ns/10ps
`include "spc_defs.vh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ref_valid;
   logic ref_write, ref_exec, ref_priv_instr, ref_gate_entry, mem_req, general_protection_fault;
   logic page_fault, fault_src;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, ref_offset, ref_desc_dw0, ref_desc_dw1, ref_pde, ref_pte, dd;
   logic [1:0] s_axi_bresp, s_axi_rresp, ref_size;
   logic [15:0] ref_sel, ref_cs_sel;
   logic [4:0] fault_cat;
   int error_cnt, cmp_count, nf, p0, g0;
   spc_checker u_dut (.*);
   spc_xcpt_model u_ptn (.*);
   // ==========================================
   // Clock, tasks
   // ==========================================
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      chk("write wait", 0, i == 50);
      chk("bresp", 0, s_axi_bresp);
   endtask
   // Read: data taken at the edge where rvalid is seen
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      chk("read data", e, s_axi_rdata & m);
      chk("rresp", 0, s_axi_rresp);
   endtask
   // Second descriptor word: class, type, level, limit high part
   function automatic logic [31:0] mkd(input logic c, input logic [3:0] t, input logic [1:0] l, input logic [3:0] h);
      return {8'h00, 4'h4, h, 1'b1, l, c, t, 8'h00};
   endfunction
   // One reference; ex 0 pass, 1 segment fault, 2 page fault
   task automatic rc(input logic [31:0] o, input logic [1:0] sz, input logic [3:0] fl, input logic [1:0] rl,
                     input logic [1:0] cl, input logic [31:0] d1, input logic [2:0] pm, input int ex,
                     input logic [4:0] cat);
      @(posedge aclk);
      ref_valid <= 1'b1;
      ref_offset <= o;
      ref_size <= sz;
      {ref_write, ref_exec, ref_priv_instr, ref_gate_entry} <= fl;
      ref_sel <= {14'h0000, rl};
      ref_cs_sel <= {14'h0000, cl};
      ref_desc_dw1 <= d1;
      ref_pde <= {29'h0000_0000, pm};
      ref_pte <= {29'h0000_0000, pm};
      @(posedge aclk);
      ref_valid <= 1'b0;
      #1;
      chk("mem_req", ex == 0, mem_req);
      chk("segment fault", ex == 1, general_protection_fault);
      chk("page fault", ex == 2, page_fault);
      if (ex == 1 && cat != 5'h00) chk("fault_cat", cat, fault_cat);
      if (ex == 2) chk("fault_src", `SPC_SRC_PAGE, fault_src);
      if (ex == 1) chk("fault_src", `SPC_SRC_SEG, fault_src);
      if (ex != 0) nf++;
   endtask
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard, far beyond the roughly 120 cycles of the tests
   initial begin
      #100000;
      error_cnt++;
      finish_test();
   end
   // ==========================================
   // Tests
   // ==========================================
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready, ref_valid, ref_offset, ref_size, ref_write, ref_exec} = '0;
      {ref_priv_instr, ref_gate_entry, ref_sel, ref_cs_sel, ref_desc_dw1, ref_pde, ref_pte} = '0;
      s_axi_wstrb = 4'hf;
      ref_desc_dw0 = 32'h0000_00ff;
      aresetn = 1'b0;
      dd = mkd(1'b1, 4'h2, 2'd3, 4'h0);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(4'h0, 32'h0, 32'h7);
      rd(4'hc, 32'h0, 32'hffff_ffff);
      rc(0, 0, 4'h0, 3, 3, mkd(1'b0, 4'h2, 2'd3, 4'h0), 3'h0, 0, 0);
      wr(4'h0, 32'h1);
      rd(4'h0, 32'h1, 32'h7);
      rc(32'hff, 0, 4'h0, 3, 3, dd, 3'h0, 0, 0);
      rc(32'h100, 0, 4'h0, 3, 3, dd, 3'h0, 1, 5'h01);
      rc(32'hfc, 2, 4'h0, 3, 3, dd, 3'h0, 0, 0);
      rc(32'hfd, 2, 4'h0, 3, 3, dd, 3'h0, 1, 5'h01);
      rc(32'h100ff, 0, 4'h0, 3, 3, mkd(1'b1, 4'h2, 2'd3, 4'h1), 3'h0, 0, 0);
      rc(32'h10100, 0, 4'h0, 3, 3, mkd(1'b1, 4'h2, 2'd3, 4'h1), 3'h0, 1, 5'h01);
      rc(0, 0, 4'h0, 3, 3, mkd(1'b0, 4'h2, 2'd3, 4'h0), 3'h0, 1, 5'h02);
      rc(0, 0, 4'h0, 3, 3, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h0, 1, 5'h04);
      rc(0, 0, 4'h0, 3, 0, mkd(1'b1, 4'h2, 2'd2, 4'h0), 3'h0, 1, 5'h04);
      rc(0, 0, 4'h0, 0, 0, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h0, 0, 0);
      rc(32'h100, 0, 4'h0, 0, 0, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h0, 1, 5'h01);
      rc(0, 0, 4'h2, 3, 3, dd, 3'h0, 1, 5'h10);
      rc(0, 0, 4'h2, 0, 0, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h0, 0, 0);
      rc(0, 0, 4'h4, 3, 3, mkd(1'b1, 4'ha, 2'd0, 4'h0), 3'h0, 1, 5'h08);
      rc(0, 0, 4'h5, 3, 3, mkd(1'b1, 4'ha, 2'd0, 4'h0), 3'h0, 0, 0);
      rc(32'hff, 0, 4'h0, 3, 3, mkd(1'b1, 4'h6, 2'd3, 4'h0), 3'h0, 1, 5'h01);
      rc(32'h100, 0, 4'h0, 3, 3, mkd(1'b1, 4'h6, 2'd3, 4'h0), 3'h0, 0, 0);
      rc(32'hfffff, 0, 4'h0, 3, 3, dd | 32'h0080_0000, 3'h0, 0, 0);
      rc(32'h100000, 0, 4'h0, 3, 3, dd | 32'h0080_0000, 3'h0, 1, 5'h01);
      // Low limit part comes from the first word only, its upper half is ignored
      @(posedge aclk);
      ref_desc_dw0 <= 32'hffff_1234;
      rc(32'h1234, 0, 4'h0, 3, 3, dd, 3'h0, 0, 0);
      rc(32'h1235, 0, 4'h0, 3, 3, dd, 3'h0, 1, 5'h01);
      @(posedge aclk);
      ref_desc_dw0 <= 32'h0000_00ff;
      rc(0, 0, 4'h0, 3, 3, dd, 3'h0, 0, 0);
      // Three references on consecutive cycles, middle one out of range
      @(posedge aclk);
      ref_valid <= 1'b1;
      #1;
      p0 = u_ptn.npass;
      g0 = u_ptn.ngp;
      @(posedge aclk);
      ref_offset <= 32'h100;
      @(posedge aclk);
      ref_offset <= 32'h0;
      @(posedge aclk);
      ref_valid <= 1'b0;
      @(posedge aclk);
      #1;
      nf++;
      chk("burst passes", p0 + 2, u_ptn.npass);
      chk("burst faults", g0 + 1, u_ptn.ngp);
      wr(4'h0, 32'h3);
      rc(0, 0, 4'h0, 3, 3, dd, 3'h1, 2, 0);
      rc(0, 0, 4'h8, 3, 3, dd, 3'h5, 2, 0);
      rc(0, 0, 4'h8, 3, 3, dd, 3'h7, 0, 0);
      rc(0, 0, 4'h8, 0, 0, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h1, 0, 0);
      wr(4'h0, 32'h7);
      rc(0, 0, 4'h8, 0, 0, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h1, 2, 0);
      rc(0, 0, 4'h0, 3, 3, mkd(1'b1, 4'h2, 2'd0, 4'h0), 3'h1, 1, 5'h04);
      wr(4'h0, 32'hffff_fff9);
      rc(32'h100, 0, 4'h0, 3, 3, dd, 3'h0, 1, 5'h01);
      rd(4'h4, 32'h0b, 32'hff);
      wr(4'h4, 32'h1);
      rd(4'h4, 32'h0, 32'h3);
      rd(4'h8, nf, 32'h0000_ffff);
      finish_test();
   end
endmodule
